// [scss_pkg.sv]
// Shared constants and types for the system clock source selector.
package scss_pkg;
  localparam logic [3:0] ADDR_OSC_CTRL = 4'h0;
  localparam logic [3:0] ADDR_AUX = 4'h4;
  localparam int ADDR_W = 4;
  localparam logic [1:0] SEL_ZERO = 2'b00;
  localparam logic [1:0] SRC_SEC = 2'b01;
  localparam logic [1:0] SRC_PRI = 2'b10;
  localparam logic [1:0] SRC_RC = 2'b11;
  localparam int BIT_IDLE = 7;
  localparam int BIT_DONE = 3;
  localparam int BIT_SEL_HI = 1;
  localparam int AUX_SEC_EN = 0;
  localparam int AUX_LOADED = 1;
  localparam int AUX_BUSY = 2;
  localparam int AUX_SRC_LO = 4;
  localparam logic [1:0] FAST_CRYSTAL_CODE = 2'b00;
  localparam logic [1:0] OLD_CYCLES = 2'h2;
  localparam logic [1:0] NEW_CYCLES = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_OLD = 2'b01,
    SW_NEW = 2'b10,
    SW_SYNC = 2'b11
  } scss_sw_t;
  typedef struct packed {
    logic reset_clock_default_cfg;
    logic [1:0] primary_osc_mode_cfg;
    logic two_speed_en;
  } scss_cfg_t;
endpackage

// [scss_top.sv]
// Clock source select register, switch sequencer and AXI4-Lite slave.
`timescale 1ns/1ps
module scss_top (
  // Clock, reset, enable.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite slave.
  input wire logic [scss_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [scss_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Configuration load and oscillator state.
  input wire scss_pkg::scss_cfg_t cfg_in,
  input wire logic cfg_loaded,
  input wire logic ost_expired,
  input wire logic [3:0] src_tick,
  input wire logic [3:0] src_stable,
  input wire logic sleep_exec,
  // Clock control outputs.
  output logic [1:0] active_src,
  output logic [1:0] pri_mode,
  output logic clk_pause,
  output logic enter_idle,
  output logic enter_sleep
);
  logic [1:0] system_clock_select, next_system_clock_select;
  logic idle_on_sleep, next_idle_on_sleep;
  logic secondary_osc_enable, next_secondary_osc_enable;
  logic start_timer_done, next_start_timer_done;
  logic cfg_taken, next_cfg_taken;
  scss_pkg::scss_cfg_t cfg, next_cfg;
  logic aw_held, w_held, next_aw_held, next_w_held, do_write;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic next_clk_pause, next_enter_idle, next_enter_sleep;
  logic [scss_pkg::ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data, next_rdata, osc_word, aux_word;
  logic [3:0] w_strb, next_w_strb;
  logic [1:0] next_bresp, next_rresp, next_pri_mode, cnt, next_cnt;
  logic [1:0] target, next_active_src, from_src, next_from_src;
  scss_pkg::scss_sw_t sw_state, next_sw_state;
  always_comb begin
    osc_word = '0;
    osc_word[scss_pkg::BIT_IDLE] = idle_on_sleep;
    osc_word[scss_pkg::BIT_DONE] = start_timer_done;
    osc_word[scss_pkg::BIT_SEL_HI:0] = system_clock_select;
    aux_word = '0;
    aux_word[scss_pkg::AUX_SEC_EN] = secondary_osc_enable;
    aux_word[scss_pkg::AUX_LOADED] = cfg_taken;
    aux_word[scss_pkg::AUX_BUSY] = clk_pause;
    aux_word[scss_pkg::AUX_SRC_LO +: 2] = active_src;
  end
  // Bus handshakes; address and data may arrive in either order.
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_awready = s_axi_awready;
    next_wready = s_axi_wready;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    do_write = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
      next_awready = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_wready = 1'b0;
    end
    if (aw_held && w_held && !s_axi_bvalid) begin
      do_write = 1'b1;
      next_bvalid = 1'b1;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bresp = (aw_addr == scss_pkg::ADDR_OSC_CTRL || aw_addr == scss_pkg::ADDR_AUX) ?
                   scss_pkg::RESP_OKAY : scss_pkg::RESP_SLVERR;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
      next_awready = 1'b1;
      next_wready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = scss_pkg::RESP_OKAY;
      case (s_axi_araddr)
        scss_pkg::ADDR_OSC_CTRL: next_rdata = osc_word;
        scss_pkg::ADDR_AUX: next_rdata = aux_word;
        default: begin
          next_rdata = '0;
          next_rresp = scss_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= scss_pkg::RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= scss_pkg::RESP_OKAY;
      s_axi_rdata <= '0;
    end else if (ce) begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end
  // Control register contents and configuration capture.
  always_comb begin
    next_system_clock_select = system_clock_select;
    next_idle_on_sleep = idle_on_sleep;
    next_secondary_osc_enable = secondary_osc_enable;
    next_cfg = cfg;
    next_cfg_taken = cfg_taken;
    next_start_timer_done = start_timer_done;
    if (cfg_loaded && !cfg_taken) begin
      next_cfg = cfg_in;
      next_cfg_taken = 1'b1;
    end
    if (do_write && w_strb[0]) begin
      if (aw_addr == scss_pkg::ADDR_OSC_CTRL) begin
        next_system_clock_select = w_data[scss_pkg::BIT_SEL_HI:0];
        next_idle_on_sleep = w_data[scss_pkg::BIT_IDLE];
      end else if (aw_addr == scss_pkg::ADDR_AUX) begin
        next_secondary_osc_enable = w_data[scss_pkg::AUX_SEC_EN];
      end
    end
    if (ost_expired && active_src == scss_pkg::SRC_PRI && !clk_pause) begin
      next_start_timer_done = 1'b1;
    end else if (!ost_expired) begin
      next_start_timer_done = 1'b0;
    end
  end
  // Reset is synchronous, so sampling the strap pins here is safe.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_clock_select <= scss_pkg::SEL_ZERO;
      idle_on_sleep <= 1'b0;
      secondary_osc_enable <= 1'b0;
      cfg <= '0;
      cfg_taken <= 1'b0;
      start_timer_done <= !(cfg_in.two_speed_en &&
        cfg_in.primary_osc_mode_cfg == scss_pkg::FAST_CRYSTAL_CODE);
    end else if (ce) begin
      system_clock_select <= next_system_clock_select;
      idle_on_sleep <= next_idle_on_sleep;
      secondary_osc_enable <= next_secondary_osc_enable;
      cfg <= next_cfg;
      cfg_taken <= next_cfg_taken;
      start_timer_done <= next_start_timer_done;
    end
  end
  // Resolve the requested source; secondary is never switched in while disabled.
  always_comb begin
    case (system_clock_select)
      scss_pkg::SEL_ZERO: target = cfg.reset_clock_default_cfg ?
                                   scss_pkg::SRC_PRI : scss_pkg::SRC_RC;
      scss_pkg::SRC_SEC: target = secondary_osc_enable ? scss_pkg::SRC_SEC : active_src;
      scss_pkg::SRC_PRI: target = scss_pkg::SRC_PRI;
      default: target = scss_pkg::SRC_RC;
    endcase
    if (!cfg_taken) begin
      target = scss_pkg::SRC_RC;
    end
  end
  // Switch sequencer: two old ticks, three new ticks, one resync cycle.
  // The resync cycle is what makes the new-clock share three to four cycles.
  always_comb begin
    next_sw_state = sw_state;
    next_cnt = cnt;
    next_active_src = active_src;
    next_from_src = from_src;
    next_clk_pause = clk_pause;
    next_pri_mode = cfg.primary_osc_mode_cfg;
    next_enter_idle = 1'b0;
    next_enter_sleep = 1'b0;
    if (sleep_exec && sw_state == scss_pkg::SW_IDLE) begin
      next_enter_idle = idle_on_sleep;
      next_enter_sleep = !idle_on_sleep;
    end
    case (sw_state)
      scss_pkg::SW_IDLE: begin
        if (target != active_src && src_stable[target]) begin
          next_sw_state = scss_pkg::SW_OLD;
          next_from_src = active_src;
          next_active_src = target;
          next_clk_pause = 1'b1;
          next_cnt = '0;
        end
      end
      scss_pkg::SW_OLD: begin
        if (src_tick[from_src]) begin
          next_cnt = cnt + 2'h1;
          if (cnt + 2'h1 == scss_pkg::OLD_CYCLES) begin
            next_sw_state = scss_pkg::SW_NEW;
            next_cnt = '0;
          end
        end
      end
      scss_pkg::SW_NEW: begin
        if (src_tick[active_src]) begin
          next_cnt = cnt + 2'h1;
          if (cnt + 2'h1 == scss_pkg::NEW_CYCLES) begin
            next_sw_state = scss_pkg::SW_SYNC;
          end
        end
      end
      scss_pkg::SW_SYNC: begin
        next_sw_state = scss_pkg::SW_IDLE;
        next_clk_pause = 1'b0;
      end
      default: next_sw_state = scss_pkg::SW_IDLE;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_state <= scss_pkg::SW_IDLE;
      cnt <= '0;
      active_src <= scss_pkg::SRC_RC;
      from_src <= scss_pkg::SRC_RC;
      clk_pause <= 1'b0;
      pri_mode <= '0;
      enter_idle <= 1'b0;
      enter_sleep <= 1'b0;
    end else if (ce) begin
      sw_state <= next_sw_state;
      cnt <= next_cnt;
      active_src <= next_active_src;
      from_src <= next_from_src;
      clk_pause <= next_clk_pause;
      pri_mode <= next_pri_mode;
      enter_idle <= next_enter_idle;
      enter_sleep <= next_enter_sleep;
    end
  end
  sequence s_sw_start;
    ce && sw_state == scss_pkg::SW_IDLE && target != active_src && src_stable[target];
  endsequence
  sequence s_paused;
    clk_pause && sw_state != scss_pkg::SW_IDLE;
  endsequence
  a_reset_select_zero: assert property (
    @(posedge aclk) !aresetn |=> system_clock_select == scss_pkg::SEL_ZERO)
    else $error("select field not cleared by reset");
  a_default_primary: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_taken && system_clock_select == scss_pkg::SEL_ZERO && cfg.reset_clock_default_cfg
    |-> target == scss_pkg::SRC_PRI)
    else $error("code 00 did not pick primary");
  a_default_rc: assert property (@(posedge aclk) disable iff (!aresetn)
    system_clock_select == scss_pkg::SEL_ZERO && !cfg.reset_clock_default_cfg
    |-> target == scss_pkg::SRC_RC)
    else $error("code 00 did not pick internal RC");
  a_rc_before_load: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg_taken && !clk_pause |-> active_src == scss_pkg::SRC_RC)
    else $error("non RC source before configuration load");
  a_cfg_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && cfg_loaded && !cfg_taken |=> cfg_taken && cfg == $past(cfg_in))
    else $error("configuration not captured");
  a_pause_held: assert property (@(posedge aclk) disable iff (!aresetn)
    s_sw_start |=> s_paused [*5])
    else $error("switch pause shorter than minimum");
  a_done_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !ost_expired |=> !start_timer_done)
    else $error("done set while timer counting");
  a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rresp == scss_pkg::RESP_OKAY &&
    $past(s_axi_araddr) == scss_pkg::ADDR_OSC_CTRL
    |-> s_axi_rdata[6:4] == 3'h0 && s_axi_rdata[2] == 1'b0)
    else $error("unimplemented bits read nonzero");
  a_sec_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(active_src) && active_src == scss_pkg::SRC_SEC |-> $past(secondary_osc_enable))
    else $error("secondary selected while disabled");
  a_sleep_kind: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && sleep_exec && sw_state == scss_pkg::SW_IDLE |=> enter_idle == $past(idle_on_sleep))
    else $error("sleep kind wrong");
endmodule

// [testbench.sv]
// Self-checking testbench for the system clock source selector.
`timescale 1ns/1ps
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, active_src, pri_mode;
  logic [31:0] s_axi_rdata;
  scss_pkg::scss_cfg_t cfg_in = '0;
  logic cfg_loaded = 1'b0;
  logic ost_expired = 1'b1;
  logic [3:0] src_tick = 4'h0;
  logic [3:0] src_stable = 4'hf;
  logic sleep_exec = 1'b0;
  logic clk_pause, enter_idle, enter_sleep;
  int seed = 89;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int plen = 0;
  int last_len = 0;
  int n_idle = 0;
  int n_sleep = 0;

  scss_top u_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .cfg_in(cfg_in), .cfg_loaded(cfg_loaded), .ost_expired(ost_expired),
    .src_tick(src_tick), .src_stable(src_stable), .sleep_exec(sleep_exec),
    .active_src(active_src), .pri_mode(pri_mode), .clk_pause(clk_pause),
    .enter_idle(enter_idle), .enter_sleep(enter_sleep)
  );

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  // Source ticks arrive at random so the pause length is exercised unevenly.
  always @(posedge aclk) begin
    src_tick <= 4'($random(seed));
    cyc <= cyc + 1;
    n_idle <= n_idle + int'(enter_idle);
    n_sleep <= n_sleep + int'(enter_sleep);
    if (clk_pause) begin
      plen <= plen + 1;
    end else if (plen != 0) begin
      last_len <= plen;
      plen <= 0;
    end
    if (cyc == 20000) begin
      n_fail++;
      final_report;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task final_report;
    $display("Compares %0d, mismatches %0d.", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w || b) begin
      @(posedge aclk);
      if (!aw && !w && b && s_axi_bvalid) begin
        b = 1'b0;
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
      end
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    @(posedge aclk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, rr;
    ar = 1'b1;
    rr = 1'b1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (ar || rr) begin
      @(posedge aclk);
      if (ar && s_axi_arready) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end else if (!ar && rr && s_axi_rvalid) begin
        rr = 1'b0;
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
    end
    @(posedge aclk);
  endtask

  // The start timer stays expired through reset so its reset value is still visible.
  task automatic do_reset(input scss_pkg::scss_cfg_t c);
    aresetn <= 1'b0;
    cfg_in <= c;
    cfg_loaded <= 1'b0;
    ost_expired <= 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // Waits for a pause to start and end; both waits are bounded.
  task automatic wait_sw;
    int k;
    k = 0;
    while (!clk_pause && k < 20) begin
      @(posedge aclk);
      k++;
    end
    k = 0;
    while (clk_pause && k < 400) begin
      @(posedge aclk);
      k++;
    end
    @(posedge aclk);
  endtask

  function automatic logic [1:0] exp_src(input logic [1:0] c, input logic d);
    return (c == 2'b00) ? (d ? scss_pkg::SRC_PRI : scss_pkg::SRC_RC) : c;
  endfunction

  initial begin
    logic [31:0] d;
    logic [1:0] r, s, cur;
    logic [1:0] codes [6];
    scss_pkg::scss_cfg_t c;
    int i;
    codes = '{2'b11, 2'b00, 2'b01, 2'b11, 2'b10, 2'b01};
    for (i = 0; i < 4; i++) begin
      // Pass 1 runs the fast crystal code without two-speed start, so done resets high.
      c = '{i[0], (i[1] ? 2'b10 : 2'b00), 1'(i != 1)};
      do_reset(c);
      repeat (3) @(posedge aclk);
      chk("src before load", 32'(scss_pkg::SRC_RC), 32'(active_src));
      rd(scss_pkg::ADDR_OSC_CTRL, d, r);
      chk("ctrl reset", {28'h0, 1'(i != 0), 3'b000}, d);
      cfg_loaded <= 1'b1;
      wait_sw;
      chk("src after load", 32'(exp_src(2'b00, i[0])), 32'(active_src));
      chk("primary mode", 32'(c.primary_osc_mode_cfg), 32'(pri_mode));
      rd(scss_pkg::ADDR_OSC_CTRL, d, r);
      chk("done set", 32'(i[0] | i[1]), 32'(d[3]));
      ost_expired <= 1'b0;
      repeat (2) @(posedge aclk);
      rd(scss_pkg::ADDR_OSC_CTRL, d, r);
      chk("done clear", 32'h0, 32'(d[3]));
    end
    wr(scss_pkg::ADDR_AUX, 32'h0, r);
    wr(scss_pkg::ADDR_OSC_CTRL, 32'h1, r);
    repeat (20) @(posedge aclk);
    chk("sec refused", 32'(scss_pkg::SRC_PRI), 32'(active_src));
    // Select 01 is still pending, so enabling the secondary oscillator starts that switch.
    wr(scss_pkg::ADDR_AUX, 32'h1, r);
    wait_sw;
    chk("sec taken", 32'(scss_pkg::SRC_SEC), 32'(active_src));
    rd(scss_pkg::ADDR_AUX, d, r);
    chk("aux status", {26'h0, scss_pkg::SRC_SEC, 4'b0011}, d);
    cur = scss_pkg::SRC_SEC;
    for (i = 0; i < 12; i++) begin
      s = (i < 6) ? codes[i] : 2'($random(seed));
      if (exp_src(s, 1'b1) != cur) begin
        // Junk in the unimplemented and read-only bits must leave no trace.
        d = ($random(seed) & 32'h7c) | 32'(s);
        wr(scss_pkg::ADDR_OSC_CTRL, d, r);
        chk("write resp", 32'(scss_pkg::RESP_OKAY), 32'(r));
        wait_sw;
        cur = exp_src(s, 1'b1);
        chk("active src", 32'(cur), 32'(active_src));
        chk("pause length", 32'h1, 32'(last_len >= 5));
        rd(scss_pkg::ADDR_OSC_CTRL, d, r);
        chk("ctrl readback", 32'(s), d & 32'hfffffff7);
      end
    end
    wr(4'h8, 32'hff, r);
    chk("unmapped write", 32'(scss_pkg::RESP_SLVERR), 32'(r));
    rd(4'h8, d, r);
    chk("unmapped read", 32'(scss_pkg::RESP_SLVERR), 32'(r));
    chk("unmapped data", 32'h0, d);
    s = (cur == scss_pkg::SRC_RC) ? scss_pkg::SRC_PRI : scss_pkg::SRC_RC;
    src_stable <= 4'h0;
    wr(scss_pkg::ADDR_OSC_CTRL, 32'(s), r);
    repeat (20) @(posedge aclk);
    chk("unstable held", 32'(cur), 32'(active_src));
    src_stable <= 4'hf;
    wait_sw;
    chk("stable switch", 32'(s), 32'(active_src));
    wr(scss_pkg::ADDR_OSC_CTRL, 32'h80 | 32'(s), r);
    sleep_exec <= 1'b1;
    @(posedge aclk);
    sleep_exec <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("idle pulses", 32'h1, 32'(n_idle));
    wr(scss_pkg::ADDR_OSC_CTRL, 32'(s), r);
    sleep_exec <= 1'b1;
    @(posedge aclk);
    sleep_exec <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("sleep pulses", 32'h1, 32'(n_sleep));
    ce <= 1'b0;
    sleep_exec <= 1'b1;
    @(posedge aclk);
    sleep_exec <= 1'b0;
    ce <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("frozen sleep", 32'h1, 32'(n_sleep));
    do_reset(c);
    rd(scss_pkg::ADDR_OSC_CTRL, d, r);
    chk("select after reset", 32'h0, d & 32'h3);
    final_report;
  end
endmodule
